// ### design/slt_dut_end.sv
// Purpose: converter boundary-scan cells with a test access port
// Assumes: link pins are asynchronous, sampled by i_clk through two flops
// Notes:   analog behaviour is shown as control outputs only
`timescale 1ns/100ps
`include "slt_regs.svh"
module slt_dut_end
  import slt_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  slt_link_if.dut         link,
  input  wire logic       i_comparator,
  output logic            o_extest,
  output logic            o_converter_power,
  output logic            o_converter_ready,
  output logic [9:0]      o_dac,
  output logic [7:0]      o_input_channel_select,
  output logic [2:0]      o_negative_input_select,
  output logic            o_gain_passgate_enable,
  output logic            o_latch_precharge,
  output logic            o_switchcap_route,
  output logic            o_supply_reference,
  output logic            o_gain_settle_assist,
  output logic            o_gain_power_on,
  output logic            o_sample,
  output logic            o_pin3_data,
  output logic            o_pin3_oe,
  output logic            o_pin3_pullup
);
  localparam int LEN = `SLT_BSR_LEN;
  logic [3:0]     sync1_ff;
  logic [3:0]     sync2_ff;
  logic           tck_d_ff;
  slt_tap_t       tap_ff;
  logic [3:0]     ir_ff;
  logic [3:0]     irsr_ff;
  logic [LEN-1:0] sr_ff;
  logic [LEN-1:0] upd_ff;
  logic           byp_ff;
  logic           tdo_ff;
  logic [3:0]     dummy_ff;
  logic           pwr_d_ff;
  logic           rise;
  logic           fall;
  logic           tms_s;
  logic           tdi_s;
  logic           comp_s;
  logic           bsr_sel;
  logic           ext;
  logic [LEN-1:0] cells;

  // order {comparator, tdi, tms, tck}; all four see the same delay
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      tck_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {i_comparator, link.tdi, link.tms, link.tck};
      sync2_ff <= sync1_ff;
      tck_d_ff <= sync2_ff[0];
    end
  end
  assign rise    = sync2_ff[0] & ~tck_d_ff;
  assign fall    = ~sync2_ff[0] & tck_d_ff;
  assign tms_s   = sync2_ff[1];
  assign tdi_s   = sync2_ff[2];
  assign comp_s  = sync2_ff[3];
  assign bsr_sel = (ir_ff == `SLT_IR_EXTEST) || (ir_ff == `SLT_IR_SAMPLE);
  assign ext     = ir_ff == `SLT_IR_EXTEST;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tap_ff <= SLT_TLR;
    end else if (rise) begin
      tap_ff <= slt_tap_next(tap_ff, tms_s);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ir_ff   <= `SLT_IR_BYPASS;
      irsr_ff <= 4'h0;
    end else if (rise) begin
      unique case (tap_ff)
        SLT_TLR:      ir_ff <= `SLT_IR_BYPASS;
        SLT_CAP_IR:   irsr_ff <= `SLT_IR_CAPTURE;
        SLT_SHIFT_IR: irsr_ff <= {tdi_s, irsr_ff[3:1]};
        SLT_UPD_IR:   ir_ff <= irsr_ff;
        default:      ;
      endcase
    end
  end

  // capture takes the comparator, the rest reads back the update register, applied or not
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sr_ff  <= '0;
      byp_ff <= 1'b0;
      upd_ff <= '0;
    end else if (fall) begin
      // update on the fall inside update, so a clock stopped there still applies
      if (tap_ff == SLT_UPD_DR && bsr_sel) upd_ff <= sr_ff;
    end else if (rise) begin
      unique case (tap_ff)
        SLT_CAP_DR: begin
          sr_ff  <= {comp_s, upd_ff[LEN-2:0]};
          byp_ff <= 1'b0;
        end
        SLT_SHIFT_DR: begin
          sr_ff  <= {tdi_s, sr_ff[LEN-1:1]};
          byp_ff <= tdi_s;
        end
        default: ;
      endcase
    end
  end

  // tdo moves on the falling link edge, the far end samples it a full period on, at its next falling edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tdo_ff <= 1'b0;
    end else if (fall) begin
      if (tap_ff == SLT_SHIFT_DR) tdo_ff <= bsr_sel ? sr_ff[0] : byp_ff;
      else if (tap_ff == SLT_SHIFT_IR) tdo_ff <= irsr_ff[0];
      else tdo_ff <= 1'b0;
    end
  end
  assign link.tdo = tdo_ff;

  // idle controls outside extest, so the converter sits quiet
  always_comb begin
    cells = '0;
    cells[`SLT_POS_CHSEL +: 8]  = `SLT_IDLE_CHSEL;
    cells[`SLT_POS_DAC +: 10]   = `SLT_DAC_MID;
    cells[`SLT_POS_HOLD]        = 1'b1;
    cells[`SLT_POS_GAIN_PASSGATE_ENABLE]      = 1'b1;
    cells[`SLT_POS_COMPARATOR_PRECHARGE_N_N]     = 1'b1;
    if (ext) cells = upd_ff;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_extest                <= 1'b0;
      o_converter_power       <= 1'b0;
      o_dac                   <= `SLT_DAC_MID;
      o_input_channel_select  <= `SLT_IDLE_CHSEL;
      o_negative_input_select <= `SLT_IDLE_NEGATIVE_INPUT_SELECT;
      o_gain_passgate_enable  <= 1'b1;
      o_latch_precharge       <= 1'b0;
      o_switchcap_route       <= 1'b0;
      o_supply_reference      <= 1'b0;
      o_gain_settle_assist    <= 1'b0;
      o_gain_power_on         <= 1'b0;
      o_sample                <= 1'b0;
      o_pin3_data             <= 1'b0;
      o_pin3_oe               <= 1'b0;
      o_pin3_pullup           <= 1'b0;
    end else begin
      o_extest                <= ext;
      o_converter_power       <= cells[`SLT_POS_POWER];
      o_dac                   <= cells[`SLT_POS_DAC +: 10];
      o_input_channel_select  <= cells[`SLT_POS_CHSEL +: 8];
      o_negative_input_select <= cells[`SLT_POS_NEGATIVE_INPUT_SELECT +: 3];
      o_gain_passgate_enable  <= cells[`SLT_POS_GAIN_PASSGATE_ENABLE];
      o_latch_precharge       <= ~cells[`SLT_POS_COMPARATOR_PRECHARGE_N_N];
      o_switchcap_route       <= cells[`SLT_POS_SWITCHCAP_TEST_ENABLE];
      o_supply_reference      <= cells[`SLT_POS_SUPREF];
      o_gain_settle_assist    <= cells[`SLT_POS_SETTLE];
      o_gain_power_on         <= cells[`SLT_POS_GAIN_ON];
      o_sample                <= cells[`SLT_POS_POWER] & ~cells[`SLT_POS_HOLD];
      o_pin3_data             <= cells[`SLT_POS_PIN_DATA];
      o_pin3_oe               <= cells[`SLT_POS_PIN_CTRL];
      o_pin3_pullup           <= cells[`SLT_POS_PIN_PU];
    end
  end

  // dummy conversion of ten comparisons after power-on
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_d_ff          <= 1'b0;
      dummy_ff          <= 4'h0;
      o_converter_ready <= 1'b0;
    end else begin
      pwr_d_ff <= cells[`SLT_POS_POWER];
      if (cells[`SLT_POS_POWER] && !pwr_d_ff) dummy_ff <= 4'(`SLT_DUMMY_CYC);
      else if (dummy_ff != 4'h0) dummy_ff <= dummy_ff - 4'h1;
      o_converter_ready <= cells[`SLT_POS_POWER] && pwr_d_ff && (dummy_ff == 4'h0);
    end
  end
endmodule

// ### design/slt_link_if.sv
// Purpose: four-wire scan link between tester and converter scan cells
// Assumes: tester drives the test clock
// Notes:   no tristate, tdo always driven
`timescale 1ns/100ps
interface slt_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport tester (output tck, output tms, output tdi, input tdo);
  modport dut    (input tck, input tms, input tdi, output tdo);
endinterface

// ### design/slt_pkg.sv
// Purpose: shared types of the converter scan link
// Assumes: standard test access port state graph
// Notes:   next-state function is used by both ends
package slt_pkg;
  typedef enum logic [3:0] {
    SLT_TLR, SLT_RTI, SLT_SEL_DR, SLT_CAP_DR, SLT_SHIFT_DR, SLT_EXIT1_DR, SLT_PAUSE_DR,
    SLT_EXIT2_DR, SLT_UPD_DR, SLT_SEL_IR, SLT_CAP_IR, SLT_SHIFT_IR, SLT_EXIT1_IR,
    SLT_PAUSE_IR, SLT_EXIT2_IR, SLT_UPD_IR
  } slt_tap_t;

  function automatic slt_tap_t slt_tap_next(input slt_tap_t s, input logic tms);
    slt_tap_t n;
    n = s;
    unique case (s)
      SLT_TLR:      n = tms ? SLT_TLR      : SLT_RTI;
      SLT_RTI:      n = tms ? SLT_SEL_DR   : SLT_RTI;
      SLT_SEL_DR:   n = tms ? SLT_SEL_IR   : SLT_CAP_DR;
      SLT_CAP_DR:   n = tms ? SLT_EXIT1_DR : SLT_SHIFT_DR;
      SLT_SHIFT_DR: n = tms ? SLT_EXIT1_DR : SLT_SHIFT_DR;
      SLT_EXIT1_DR: n = tms ? SLT_UPD_DR   : SLT_PAUSE_DR;
      SLT_PAUSE_DR: n = tms ? SLT_EXIT2_DR : SLT_PAUSE_DR;
      SLT_EXIT2_DR: n = tms ? SLT_UPD_DR   : SLT_SHIFT_DR;
      SLT_UPD_DR:   n = tms ? SLT_SEL_DR   : SLT_RTI;
      SLT_SEL_IR:   n = tms ? SLT_TLR      : SLT_CAP_IR;
      SLT_CAP_IR:   n = tms ? SLT_EXIT1_IR : SLT_SHIFT_IR;
      SLT_SHIFT_IR: n = tms ? SLT_EXIT1_IR : SLT_SHIFT_IR;
      SLT_EXIT1_IR: n = tms ? SLT_UPD_IR   : SLT_PAUSE_IR;
      SLT_PAUSE_IR: n = tms ? SLT_EXIT2_IR : SLT_PAUSE_IR;
      SLT_EXIT2_IR: n = tms ? SLT_UPD_IR   : SLT_SHIFT_IR;
      SLT_UPD_IR:   n = tms ? SLT_SEL_DR   : SLT_RTI;
    endcase
    return n;
  endfunction

  typedef enum logic [2:0] {SLT_T_IDLE, SLT_T_RESET, SLT_T_RUN, SLT_T_WAIT, SLT_T_DONE} slt_tst_t;
endpackage

// ### design/slt_regs.svh
// Purpose: bit positions, codes and timing counts of the converter scan link
// Assumes: 50 MHz system clock on both ends
// Notes:   bit 0 is the first bit shifted in and out
`ifndef SLT_REGS_SVH
`define SLT_REGS_SVH

`define SLT_BSR_LEN       33
`define SLT_POS_PIN_DATA  0
`define SLT_POS_PIN_CTRL  1
`define SLT_POS_PIN_PU    2
`define SLT_POS_SUPREF    3
`define SLT_POS_SETTLE    4
`define SLT_POS_SWITCHCAP_TEST_ENABLE    5
`define SLT_POS_COMPARATOR_PRECHARGE_N_N   6
`define SLT_POS_GAIN_PASSGATE_ENABLE    7
`define SLT_POS_NEGATIVE_INPUT_SELECT    8
`define SLT_POS_CHSEL     11
`define SLT_POS_HOLD      19
`define SLT_POS_DAC       20
`define SLT_POS_GAIN_ON   30
`define SLT_POS_POWER     31
`define SLT_POS_COMP      32

`define SLT_IR_LEN        4
`define SLT_IR_EXTEST     4'h0
`define SLT_IR_SAMPLE     4'h2
`define SLT_IR_BYPASS     4'hf
`define SLT_IR_CAPTURE    4'h1

`define SLT_DAC_MID       10'h200
`define SLT_IDLE_CHSEL    8'h01
`define SLT_IDLE_NEGATIVE_INPUT_SELECT   3'h0

`define SLT_CLK_NS        20
`define SLT_DUMMY_NS      200
`define SLT_DUMMY_CYC     ((`SLT_DUMMY_NS + `SLT_CLK_NS - 1) / `SLT_CLK_NS)
`define SLT_RESET_TMS     5
`define SLT_LAST_PC       12

`endif

// ### design/slt_tester_end.sv
// Purpose: scan tester that checks a converter input against a voltage window
// Assumes: tdo arrives asynchronously and passes two flops
// Notes:   test clock made here by a divider; one window check per start
//
// Contract
// - unused controls driven to their idle values
// - negative select field, three bits, held low
// - precharge control treated as active low
// - settle assist high two gain clocks after power; mk_vec holds it low, with the gain stage off
// - switchcap test routes x10 gain to pin
// - supply reference select uses supply as reference
// - exactly one negative sample source selected
// - differential gain stages left unused during scan
// - lower limit gives low, upper gives high
// - measured pin is input, pull-up off
// - wait 200ns after converter power-on
// - trial value at midpoint while sampling
// - first vector preloaded, rest under extest
// - hold low, high, limit, precharge, restore
// - expect result zero then one
// - test clock fast enough for hold time
// - sample while hold low, hold while high
// - power control powers the converter
// - bit zero shifted first, controls at top
`timescale 1ns/100ps
`include "slt_regs.svh"
module slt_tester_end
  import slt_pkg::*;
#(
  parameter int HALF_CYC = 4,
  parameter int WAIT_CYC = `SLT_DUMMY_CYC
)(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  slt_link_if.tester      link,
  input  wire logic       i_start,
  input  wire logic [7:0] i_channel_sel,
  input  wire logic [9:0] i_lower,
  input  wire logic [9:0] i_upper,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_lower_ok,
  output logic            o_upper_ok,
  output logic            o_pass
);
  localparam int LEN = `SLT_BSR_LEN;
  slt_tst_t       st_ff;
  slt_tap_t       tap_ff;
  logic [7:0]     div_ff;
  logic           tck_ff;
  logic           tms_ff;
  logic           tdi_ff;
  logic           tdo1_ff;
  logic           tdo2_ff;
  logic           was_shift_ff;
  logic [3:0]     pc_ff;
  logic [5:0]     cnt_ff;
  logic [LEN-1:0] tx_ff;
  logic [LEN-1:0] rx_ff;
  logic [7:0]     chsel_ff;
  logic [9:0]     lower_ff;
  logic [9:0]     upper_ff;
  logic           tick;
  logic           op_ir;
  logic [LEN-1:0] op_data;
  logic [5:0]     op_len;

  // one converter vector; power cell set high, all other controls not named sit at idle values
  function automatic logic [LEN-1:0] mk_vec(input logic [9:0] dac, input logic hold,
                                            input logic comparator_precharge_n_n, input logic [7:0] ch);
    logic [LEN-1:0] v;
    v = '0;
    v[`SLT_POS_POWER]       = 1'b1;
    v[`SLT_POS_DAC +: 10]   = dac;
    v[`SLT_POS_CHSEL +: 8]  = ch;
    v[`SLT_POS_HOLD]        = hold;
    v[`SLT_POS_COMPARATOR_PRECHARGE_N_N]     = comparator_precharge_n_n;
    v[`SLT_POS_GAIN_PASSGATE_ENABLE]      = 1'b1;
    v[`SLT_POS_NEGATIVE_INPUT_SELECT +: 3] = `SLT_IDLE_NEGATIVE_INPUT_SELECT;
    v[`SLT_POS_GAIN_ON]     = 1'b0;
    v[`SLT_POS_SETTLE]      = 1'b0;
    v[`SLT_POS_SWITCHCAP_TEST_ENABLE]      = 1'b0;
    v[`SLT_POS_SUPREF]      = 1'b0;
    v[`SLT_POS_PIN_CTRL +: 2] = 2'h0;
    v[`SLT_POS_PIN_DATA]    = 1'b0;
    return v;
  endfunction

  // negative input comes from ground only through the idle select
  always_comb begin
    op_ir   = 1'b0;
    op_len  = 6'(LEN);
    op_data = mk_vec(`SLT_DAC_MID, 1'b1, 1'b1, chsel_ff);
    unique case (pc_ff)
      4'h0: begin
        op_ir   = 1'b1;
        op_len  = 6'(`SLT_IR_LEN);
        op_data = LEN'(`SLT_IR_SAMPLE);
      end
      4'h2: begin
        op_ir   = 1'b1;
        op_len  = 6'(`SLT_IR_LEN);
        op_data = LEN'(`SLT_IR_EXTEST);
      end
      4'h3, 4'h8: op_data = mk_vec(`SLT_DAC_MID, 1'b0, 1'b1, chsel_ff);
      4'h5:  op_data = mk_vec(lower_ff, 1'b1, 1'b1, chsel_ff);
      4'h6:  op_data = mk_vec(lower_ff, 1'b1, 1'b0, chsel_ff);
      4'ha:  op_data = mk_vec(upper_ff, 1'b1, 1'b1, chsel_ff);
      4'hb:  op_data = mk_vec(upper_ff, 1'b1, 1'b0, chsel_ff);
      default: ;
    endcase
  end

  // divider; HALF_CYC sets the test clock, which must outrun the hold droop
  assign tick = div_ff == 8'(HALF_CYC - 1);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_ff <= 8'h0;
      tck_ff <= 1'b0;
    end else if (st_ff == SLT_T_RESET || st_ff == SLT_T_RUN || tck_ff) begin
      div_ff <= tick ? 8'h0 : div_ff + 8'h1;
      if (tick) tck_ff <= ~tck_ff;
    end else begin
      div_ff <= 8'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tdo1_ff <= 1'b0;
      tdo2_ff <= 1'b0;
    end else begin
      tdo1_ff <= link.tdo;
      tdo2_ff <= tdo1_ff;
    end
  end

  // mirror of the far state machine, stepped on our own rising edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tap_ff       <= SLT_TLR;
      was_shift_ff <= 1'b0;
    end else if (tick && !tck_ff) begin
      tap_ff       <= slt_tap_next(tap_ff, tms_ff);
      was_shift_ff <= tap_ff == SLT_SHIFT_DR;
    end
  end

  // falling-edge work: drive tms/tdi, collect the shifted-out bit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff      <= SLT_T_IDLE;
      tms_ff     <= 1'b1;
      tdi_ff     <= 1'b0;
      pc_ff      <= 4'h0;
      cnt_ff     <= 6'h0;
      tx_ff      <= '0;
      rx_ff      <= '0;
      chsel_ff   <= 8'h0;
      lower_ff   <= 10'h0;
      upper_ff   <= 10'h0;
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
      o_lower_ok <= 1'b0;
      o_upper_ok <= 1'b0;
      o_pass     <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (st_ff)
        SLT_T_IDLE, SLT_T_DONE: if (i_start && !tck_ff) begin
          st_ff      <= SLT_T_RESET;
          chsel_ff   <= i_channel_sel;
          lower_ff   <= i_lower;
          upper_ff   <= i_upper;
          pc_ff      <= 4'h0;
          cnt_ff     <= 6'h0;
          tms_ff     <= 1'b1;
          o_busy     <= 1'b1;
          o_lower_ok <= 1'b0;
          o_upper_ok <= 1'b0;
          o_pass     <= 1'b0;
        end
        SLT_T_RESET: if (tick && tck_ff) begin
          cnt_ff <= cnt_ff + 6'h1;
          if (cnt_ff == 6'(`SLT_RESET_TMS - 1)) begin
            tms_ff <= 1'b0;
            st_ff  <= SLT_T_RUN;
          end
        end
        SLT_T_WAIT: begin
          cnt_ff <= cnt_ff + 6'h1;
          if (cnt_ff == 6'(WAIT_CYC)) st_ff <= SLT_T_RUN;
        end
        SLT_T_RUN: if (tick && tck_ff) begin
          if (was_shift_ff) rx_ff <= {tdo2_ff, rx_ff[LEN-1:1]};
          unique case (tap_ff)
            SLT_RTI:    tms_ff <= 1'b1;
            SLT_SEL_DR: tms_ff <= op_ir;
            SLT_SEL_IR: tms_ff <= 1'b0;
            // the rise leaving capture does not shift, bit 0 goes out inside shift
            SLT_CAP_DR, SLT_CAP_IR: begin
              tx_ff  <= op_data;
              cnt_ff <= 6'h0;
              tms_ff <= 1'b0;
            end
            SLT_SHIFT_DR, SLT_SHIFT_IR: begin
              tdi_ff <= tx_ff[0];
              tx_ff  <= tx_ff >> 1;
              cnt_ff <= cnt_ff + 6'h1;
              tms_ff <= cnt_ff == op_len - 6'h1;
            end
            SLT_EXIT1_DR, SLT_EXIT1_IR: tms_ff <= 1'b1;
            SLT_UPD_DR, SLT_UPD_IR: begin
              tms_ff <= 1'b0;
              pc_ff  <= pc_ff + 4'h1;
              if (pc_ff == 4'h7) o_lower_ok <= ~rx_ff[`SLT_POS_COMP];
              if (pc_ff == 4'(`SLT_LAST_PC)) begin
                o_upper_ok <= rx_ff[`SLT_POS_COMP];
                o_pass     <= o_lower_ok & rx_ff[`SLT_POS_COMP];
                o_busy     <= 1'b0;
                o_done     <= 1'b1;
                st_ff      <= SLT_T_DONE;
              end else if (pc_ff == 4'h3) begin
                cnt_ff <= 6'h0;
                st_ff  <= SLT_T_WAIT;
              end
            end
            default: tms_ff <= 1'b1;
          endcase
        end
      endcase
    end
  end

  assign link.tck = tck_ff;
  assign link.tms = tms_ff;
  assign link.tdi = tdi_ff;
endmodule

// ### verification/slt_link_chk.sv
// Purpose: link checks between tester and converter scan ends
// Assumes: tck, tms, tdi and tdo sampled on i_clk
// Notes:   rebuilds the tap state to decode each shifted vector
`timescale 1ns/100ps
`include "slt_regs.svh"
module slt_link_chk
  import slt_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic tdo
);
  logic        tck_ff;
  slt_tap_t    tap_ff;
  logic [32:0] dr_ff;
  logic [5:0]  drn_ff;
  logic [3:0]  ir_ff;
  logic [2:0]  irn_ff;
  logic [1:0]  iro_ff;
  logic        pre_ff;
  logic        rise;
  logic        fall;
  logic        upd;
  assign rise = tck && !tck_ff;
  assign fall = !tck && tck_ff;
  assign upd  = fall && tap_ff == SLT_UPD_DR;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tck_ff <= 1'b0;
      tap_ff <= SLT_TLR;
    end else begin
      tck_ff <= tck;
      if (rise) tap_ff <= slt_tap_next(tap_ff, tms);
    end
  end
  // shifted bits kept whole so a vector is judged only at update
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dr_ff  <= '0;
      drn_ff <= 6'h0;
      ir_ff  <= 4'h0;
      irn_ff <= 3'h0;
      iro_ff <= 2'h0;
      pre_ff <= 1'b1;
    end else if (upd) begin
      pre_ff <= dr_ff[`SLT_POS_COMPARATOR_PRECHARGE_N_N];
    end else if (rise) begin
      if (tap_ff == SLT_CAP_DR) drn_ff <= 6'h0;
      if (tap_ff == SLT_SHIFT_DR) begin
        dr_ff  <= {tdi, dr_ff[32:1]};
        drn_ff <= drn_ff + 6'h1;
      end
      if (tap_ff == SLT_CAP_IR) irn_ff <= 3'h0;
      if (tap_ff == SLT_SHIFT_IR) begin
        ir_ff  <= {tdi, ir_ff[3:1]};
        irn_ff <= irn_ff + 3'h1;
      end
      if (tap_ff == SLT_TLR) iro_ff <= 2'h0;
      if (tap_ff == SLT_UPD_IR && iro_ff != 2'h3) iro_ff <= iro_ff + 2'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  tck_high_a: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
    else $error("test clock high phase wrong");
  tck_low_a: assert property ($fell(tck) |-> !tck [*4])
    else $error("test clock low phase too short");
  link_stable_a: assert property (tck && tck_ff |-> $stable(tms) && $stable(tdi))
    else $error("tms or tdi moved while tck high");
  tdo_stable_a: assert property ($fell(tck) |-> $stable(tdo) [*2])
    else $error("tdo moved at tck fall");
  dr_len_a: assert property (rise && tap_ff == SLT_SHIFT_DR && tms |-> drn_ff == 6'd32)
    else $error("data shift length wrong");
  ir_len_a: assert property (rise && tap_ff == SLT_SHIFT_IR && tms |-> irn_ff == 3'd3)
    else $error("instruction shift length wrong");
  ir_order_a: assert property (rise && tap_ff == SLT_UPD_IR |->
    ir_ff == (iro_ff == 2'h0 ? `SLT_IR_SAMPLE : `SLT_IR_EXTEST))
    else $error("instruction order wrong");
  idle_ctrl_a: assert property (upd |-> dr_ff[`SLT_POS_GAIN_PASSGATE_ENABLE] && dr_ff[5:3] == 3'h0)
    else $error("idle controls not idle");
  negative_input_select_low_a: assert property (upd |-> dr_ff[`SLT_POS_NEGATIVE_INPUT_SELECT +: 3] == 3'h0)
    else $error("negative select not low");
  pin_input_a: assert property (upd |-> dr_ff[2:0] == 3'h0)
    else $error("measured pin not plain input");
  power_on_a: assert property (upd |-> dr_ff[`SLT_POS_POWER])
    else $error("converter power cell low");
  gain_off_a: assert property (upd |-> !dr_ff[`SLT_POS_GAIN_ON])
    else $error("gain stage powered");
  one_chan_a: assert property (upd |-> $onehot(dr_ff[`SLT_POS_CHSEL +: 8]))
    else $error("channel select not one hot");
  sample_mid_a: assert property (upd && !dr_ff[`SLT_POS_HOLD] |->
    dr_ff[`SLT_POS_DAC +: 10] == `SLT_DAC_MID)
    else $error("trial value moved while sampling");
  comparator_precharge_n_limit_a: assert property (upd && !dr_ff[`SLT_POS_COMPARATOR_PRECHARGE_N_N] |->
    dr_ff[`SLT_POS_HOLD] && dr_ff[`SLT_POS_DAC +: 10] != `SLT_DAC_MID)
    else $error("precharge without held limit");
  restore_a: assert property (upd && !pre_ff |->
    dr_ff[`SLT_POS_COMPARATOR_PRECHARGE_N_N] && dr_ff[`SLT_POS_DAC +: 10] == `SLT_DAC_MID)
    else $error("vector after precharge not restored");
endmodule

// ### verification/tb.sv
// Purpose: self-checking bench for both ends of the converter scan link
// Assumes: tester divider gives a 160 ns test clock
// Notes:   comparator modelled from a held input code against the trial value
`timescale 1ns/100ps
`include "slt_regs.svh"
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module tb;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_start = 1'b0;
  logic        i_comparator = 1'b0;
  logic [7:0]  i_channel_sel = 8'h08;
  logic [9:0]  i_lower = 10'h123;
  logic [9:0]  i_upper = 10'h143;
  logic        o_busy, o_done, o_lower_ok, o_upper_ok, o_pass, o_extest, o_sample;
  logic        o_converter_power, o_converter_ready, o_gain_passgate_enable;
  logic        o_latch_precharge, o_switchcap_route, o_supply_reference;
  logic        o_gain_settle_assist, o_gain_power_on, o_pin3_data, o_pin3_oe, o_pin3_pullup;
  logic [9:0]  o_dac;
  logic [7:0]  o_input_channel_select;
  logic [2:0]  o_negative_input_select;
  logic [20:0] ana;
  logic [7:0]  flg;
  logic [9:0]  vin = 10'h130;
  logic [9:0]  held = 10'h0;
  logic [31:0] rnd = 32'h99f9;
  int          err_total = 0;
  int          total_checks = 0;
  int          pwr_n = 0;
  int          k;
  slt_link_if link ();
  assign ana = {o_dac, o_input_channel_select, o_negative_input_select};
  assign flg = {o_gain_passgate_enable, o_latch_precharge, o_extest, o_converter_power,
                o_sample, o_busy, link.tck, link.tms};
  slt_tester_end #(.HALF_CYC(4), .WAIT_CYC(`SLT_DUMMY_CYC)) i_slt_tester_end (
    .i_clk, .i_rst_b, .link(link.tester), .i_start, .i_channel_sel, .i_lower, .i_upper,
    .o_busy, .o_done, .o_lower_ok, .o_upper_ok, .o_pass);
  slt_dut_end i_slt_dut_end (
    .i_clk, .i_rst_b, .link(link.dut), .i_comparator, .o_extest, .o_converter_power,
    .o_converter_ready, .o_dac, .o_input_channel_select, .o_negative_input_select,
    .o_gain_passgate_enable, .o_latch_precharge, .o_switchcap_route, .o_supply_reference,
    .o_gain_settle_assist, .o_gain_power_on, .o_sample, .o_pin3_data, .o_pin3_oe,
    .o_pin3_pullup);
  slt_link_chk i_slt_link_chk (
    .i_clk, .i_rst_b, .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo));
  always #10 i_clk = ~i_clk;
  // latch follows only while o_latch_precharge is high, so a swapped polarity reads mid code
  always @(negedge i_clk) begin
    if (o_sample === 1'b1) held <= vin;
    if (o_latch_precharge === 1'b1) i_comparator <= (o_dac > held);
    pwr_n = (o_converter_power === 1'b1) ? pwr_n + 1 : 0;
    if (o_sample === 1'b1) `CHK("dac_sampling", `SLT_DAC_MID, o_dac);
    if (o_converter_ready === 1'b1 && pwr_n < 10) `CHK("ready_early", 1'b0, 1'b1);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] expect_ok(input logic [9:0] v, input logic [9:0] lo,
                                           input logic [9:0] hi);
    return {v >= lo, hi > v, v >= lo && hi > v};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic idle_check;
    `CHK("idle_ana", {`SLT_DAC_MID, `SLT_IDLE_CHSEL, `SLT_IDLE_NEGATIVE_INPUT_SELECT}, ana);
    `CHK("idle_flags", 8'h81, flg);
  endtask
  // start pulse mid-run and scrambled limits must both be ignored
  task automatic run(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi,
                     input logic [7:0] ch, input int cut);
    logic [2:0] e;
    int         n;
    e = expect_ok(v, lo, hi);
    @(negedge i_clk);
    vin = v;
    {i_lower, i_upper, i_channel_sel} = {lo, hi, ch};
    i_start = 1'b1;
    for (n = 0; n < 20000 && o_done !== 1'b1 && n != cut; n++) begin
      @(negedge i_clk);
      i_start = (n == 300);
      if (n == 301) {i_lower, i_upper} = ~{lo, hi};
    end
    if (n == cut) begin
      i_rst_b = 1'b0;
      repeat (2) @(negedge i_clk);
      idle_check();
      i_rst_b = 1'b1;
    end else if (o_done !== 1'b1) begin
      err_total++;
      final_report();
    end else begin
      `CHK("window", e, {o_lower_ok, o_upper_ok, o_pass});
      repeat (4) @(negedge i_clk);
      `CHK("busy", 1'b0, o_busy);
      `CHK("power", 3'h7, {o_extest, o_converter_power, o_converter_ready});
      `CHK("ana", {`SLT_DAC_MID, ch, 3'h0}, ana);
      `CHK("passgate", 1'b1, o_gain_passgate_enable);
      `CHK("latch", 2'h0, {o_latch_precharge, o_sample});
      `CHK("route", 2'h0, {o_switchcap_route, o_supply_reference});
      `CHK("gain", 2'h0, {o_gain_settle_assist, o_gain_power_on});
      `CHK("pin", 3'h0, {o_pin3_data, o_pin3_oe, o_pin3_pullup});
    end
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    idle_check();
    i_rst_b = 1'b1;
    run(10'h130, 10'h123, 10'h143, 8'h08, -1);
    run(10'h123, 10'h123, 10'h143, 8'h08, -1);
    run(10'h143, 10'h123, 10'h143, 8'h08, -1);
    run(10'h122, 10'h123, 10'h143, 8'h08, -1);
    run(10'h130, 10'h123, 10'h143, 8'h08, 1500);
    for (k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      run({2'b00, rnd[7:0]} + 10'h50 - 10'h10 + {5'h0, rnd[20:16]}, {2'b00, rnd[7:0]} + 10'h40,
          {2'b00, rnd[7:0]} + 10'h41 + {5'h0, rnd[12:8]}, 8'h01 << rnd[26:24], -1);
    end
    final_report();
  end
endmodule
